// ---- include/lfipc_defines.svh ----
// Offsets, field positions, reset values and timing counts of the LDO fault block.
// Definitions only; included by bare name from the design and the testbench.
`ifndef LFIPC_DEFINES_SVH
`define LFIPC_DEFINES_SVH

`define LFIPC_OFF_FLAGS       8'h00
`define LFIPC_OFF_MASK        8'h04
`define LFIPC_OFF_LIVE        8'h08
`define LFIPC_OFF_COIN        8'h0C
`define LFIPC_OFF_PWR         8'h10
`define LFIPC_OFF_EVT_STAT    8'h14
`define LFIPC_OFF_EVT_CLR     8'h18
`define LFIPC_OFF_EVT_EN      8'h1C

`define LFIPC_LDO_N           6
`define LFIPC_EVT_N           4
`define LFIPC_COIN_EN_BIT     3
`define LFIPC_COIN_VSEL_MSB   2
`define LFIPC_COIN_VSEL_LSB   0
`define LFIPC_SCP_BIT         7
`define LFIPC_STBY_INV_BIT    6
`define LFIPC_STBY_DLY_MSB    5
`define LFIPC_STBY_DLY_LSB    4
`define LFIPC_DBNC_MSB        3
`define LFIPC_DBNC_LSB        2
`define LFIPC_LP_EN_BIT       1
`define LFIPC_RESTART_BIT     0

`define LFIPC_EVT_STBY        0
`define LFIPC_EVT_OFF         1
`define LFIPC_EVT_RESTART     2
`define LFIPC_EVT_PRESS       3

`define LFIPC_RST_FLAGS       6'h00
`define LFIPC_RST_MASK        6'h3F
`define LFIPC_RST_COIN        4'h0
`define LFIPC_RST_PWR         8'h10
`define LFIPC_RST_EVT_EN      4'h0

`define LFIPC_RESP_OKAY       2'h0
`define LFIPC_RESP_SLVERR     2'h2

`define LFIPC_CLK_KHZ         32'h186A0
`define LFIPC_SLOW_KHZ        32'h20
`define LFIPC_SLOW_TICK_CYCLES (`LFIPC_CLK_KHZ / `LFIPC_SLOW_KHZ)
`define LFIPC_LONG_PRESS_S    32'h4
`define LFIPC_LONG_PRESS_CYCLES (`LFIPC_LONG_PRESS_S * `LFIPC_CLK_KHZ * 32'h3E8)

`define LFIPC_DBNC_TICKS_0    8'h01
`define LFIPC_DBNC_TICKS_1    8'h04
`define LFIPC_DBNC_TICKS_2    8'h10
`define LFIPC_DBNC_TICKS_3    8'h40

`endif

// ---- include/lfipc_pkg.sv ----
// Types of the LDO fault interrupt and power control block.
// Constants live in lfipc_defines.svh.
package lfipc_pkg;

	typedef enum logic [1:0] {
		PS_ON      = 2'h0,
		PS_HOLD    = 2'h1,
		PS_OFF     = 2'h3,
		PS_RESTART = 2'h2
	} lfipc_pwr_state_t;

	typedef logic [1:0] lfipc_resp_t;

endpackage

// ---- verilog/lfipc_top.sv ----
// LDO overcurrent flags, mask and live sense, backup cell charger and power control.
// Assumes one 100 MHz clock, an AXI4-Lite master, and asynchronous analog inputs.
// Notes on behaviour
// - A regulator in current limit sets its overcurrent flag, bits 5 down to 0.
// - Flags clear only by writing 1; writing 0 leaves them.
// - Mask bit 0 unmasks the flag at the same position, 1 masks it.
// - Mask bits sit at the same positions as their flags.
// - Interrupt pin follows every unmasked flag; masked flags do not reach it.
// - Live bits show the current-limit state now, 1 meaning above limit.
// - Live register is readable anytime; reset value is 0, then it follows the regulators.
// - Charger control bit 3 enables the backup cell charger.
// - Charger bits 2:0 select target voltage 2.50 V to 3.30 V, driven out.
// - With short protect bit 7 set, a current-limited LDO is shut down.
// - Power control bit 6 makes the standby pin active low when 1.
// - Standby entry waits 0 to 3 slow periods per delay field, default one.
// - Two-bit debounce field selects the power button debounce time.
// - With bit 1 set, button held low 4 s or more enters off mode.
// - With bit 0 set and config input 1, restart after long-press off.
`timescale 1ns/1ps
`include "lfipc_defines.svh"

module lfipc_top
	import lfipc_pkg::*;
#(
	parameter logic [31:0] LONG_PRESS_CYCLES = `LFIPC_LONG_PRESS_CYCLES
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic [5:0]  ldo_current_limit,
	input  wire logic        standby_pin,
	input  wire logic        power_button_input,
	input  wire logic        power_config_select,
	output logic             interrupt_out_pin_n,
	output logic [5:0]       ldo_shutdown,
	output logic             backup_charger_enable,
	output logic [2:0]       backup_charger_voltage_sel,
	output logic             standby_active,
	output logic             power_off,
	output logic             restart_pulse
);

	logic [5:0]             limit_s1;
	logic [5:0]             live_q;
	logic                   stby_s1;
	logic                   stby_s2;
	logic                   btn_s1;
	logic                   btn_s2;
	logic                   cfg_s1;
	logic                   cfg_s2;
	logic                   aw_held;
	logic [7:0]             aw_addr_q;
	logic                   w_held;
	logic [31:0]            w_data_q;
	logic [3:0]             w_strb_q;
	logic                   wr_fire;
	logic                   wr_b0;
	logic [5:0]             flag_clr;
	logic [3:0]             evt_clr;
	logic [5:0]             flags_reg;
	logic [5:0]             mask_reg;
	logic [3:0]             coin_reg;
	logic [7:0]             pwr_reg;
	logic [3:0]             evt_reg;
	logic [3:0]             evt_en_reg;
	logic [3:0]             evt_set;
	logic [31:0]            rd_value;
	logic                   rd_ok;
	logic [11:0]            tick_cnt;
	logic                   slow_tick;
	logic [7:0]             dbnc_cnt;
	logic                   btn_db;
	logic                   press_evt;
	logic                   stby_req;
	logic [1:0]             stby_cnt;
	logic                   standby_next;
	logic [31:0]            lp_cnt;
	lfipc_pwr_state_t       pstate_reg;
	lfipc_pwr_state_t       pstate_next;
	logic                   restart_ok;

	function automatic logic reg_mapped(input logic [7:0] a);
		reg_mapped = (a == `LFIPC_OFF_FLAGS) || (a == `LFIPC_OFF_MASK) ||
			(a == `LFIPC_OFF_LIVE) || (a == `LFIPC_OFF_COIN) ||
			(a == `LFIPC_OFF_PWR) || (a == `LFIPC_OFF_EVT_STAT) ||
			(a == `LFIPC_OFF_EVT_CLR) || (a == `LFIPC_OFF_EVT_EN);
	endfunction

	function automatic logic [7:0] dbnc_ticks(input logic [1:0] sel);
		unique case (sel)
			2'h0: dbnc_ticks = `LFIPC_DBNC_TICKS_0;
			2'h1: dbnc_ticks = `LFIPC_DBNC_TICKS_1;
			2'h2: dbnc_ticks = `LFIPC_DBNC_TICKS_2;
			2'h3: dbnc_ticks = `LFIPC_DBNC_TICKS_3;
		endcase
	endfunction

	// Input synchronisers; the analog comparators are not on aclk
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			limit_s1 <= 6'h00;
			live_q   <= 6'h00;
			stby_s1  <= 1'b0;
			stby_s2  <= 1'b0;
			btn_s1   <= 1'b1;
			btn_s2   <= 1'b1;
			cfg_s1   <= 1'b0;
			cfg_s2   <= 1'b0;
		end else begin
			limit_s1 <= ldo_current_limit;
			live_q   <= limit_s1;
			stby_s1  <= standby_pin;
			stby_s2  <= stby_s1;
			btn_s1   <= power_button_input;
			btn_s2   <= btn_s1;
			cfg_s1   <= power_config_select;
			cfg_s2   <= cfg_s1;
		end
	end

	// AXI4-Lite write: address and data taken in either order
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready  = !w_held && !s_axi_bvalid;
	assign wr_fire       = aw_held && w_held && !s_axi_bvalid;
	assign wr_b0         = wr_fire && w_strb_q[0];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held     <= 1'b0;
			aw_addr_q   <= 8'h00;
			w_held      <= 1'b0;
			w_data_q    <= 32'h0000_0000;
			w_strb_q    <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `LFIPC_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held   <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held   <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= reg_mapped(aw_addr_q) ? `LFIPC_RESP_OKAY : `LFIPC_RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	assign flag_clr = (wr_b0 && aw_addr_q == `LFIPC_OFF_FLAGS) ? w_data_q[5:0] : 6'h00;
	assign evt_clr  = (wr_b0 && aw_addr_q == `LFIPC_OFF_EVT_CLR) ? w_data_q[3:0] : 4'h0;

	// Set beats clear so a fault arriving during the clear write is kept
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flags_reg <= `LFIPC_RST_FLAGS;
		end else begin
			flags_reg <= (flags_reg & ~flag_clr) | live_q;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mask_reg   <= `LFIPC_RST_MASK;
			coin_reg   <= `LFIPC_RST_COIN;
			pwr_reg    <= `LFIPC_RST_PWR;
			evt_en_reg <= `LFIPC_RST_EVT_EN;
		end else if (wr_b0) begin
			unique case (aw_addr_q)
				`LFIPC_OFF_MASK:   mask_reg   <= w_data_q[5:0];
				`LFIPC_OFF_COIN:   coin_reg   <= w_data_q[3:0];
				`LFIPC_OFF_PWR:    pwr_reg    <= w_data_q[7:0];
				`LFIPC_OFF_EVT_EN: evt_en_reg <= w_data_q[3:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			evt_reg <= 4'h0;
		end else begin
			evt_reg <= (evt_reg & ~evt_clr) | evt_set;
		end
	end

	// AXI4-Lite read, answered at the same edge that takes the address
	assign s_axi_arready = !s_axi_rvalid;

	always_comb begin
		rd_value = 32'h0000_0000;
		rd_ok    = 1'b1;
		unique case (s_axi_araddr)
			`LFIPC_OFF_FLAGS:    rd_value[5:0] = flags_reg;
			`LFIPC_OFF_MASK:     rd_value[5:0] = mask_reg;
			`LFIPC_OFF_LIVE:     rd_value[5:0] = live_q;
			`LFIPC_OFF_COIN:     rd_value[3:0] = coin_reg;
			`LFIPC_OFF_PWR:      rd_value[7:0] = pwr_reg;
			`LFIPC_OFF_EVT_STAT: rd_value[3:0] = evt_reg;
			`LFIPC_OFF_EVT_CLR:  rd_value     = 32'h0000_0000;
			`LFIPC_OFF_EVT_EN:   rd_value[3:0] = evt_en_reg;
			default:             rd_ok        = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= `LFIPC_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_value;
			s_axi_rresp  <= (rd_ok && reg_mapped(s_axi_araddr)) ?
				`LFIPC_RESP_OKAY : `LFIPC_RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// Registered so the pin never glitches between flag updates
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			interrupt_out_pin_n <= 1'b1;
		end else begin
			interrupt_out_pin_n <= !(|(flags_reg & ~mask_reg) | |(evt_reg & evt_en_reg));
		end
	end

	assign backup_charger_enable      = coin_reg[`LFIPC_COIN_EN_BIT];
	assign backup_charger_voltage_sel = coin_reg[`LFIPC_COIN_VSEL_MSB:`LFIPC_COIN_VSEL_LSB];

	// Latched off until protection is disabled or the flag is cleared
	genvar gi;
	generate
		for (gi = 0; gi < `LFIPC_LDO_N; gi++) begin : g_scp
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					ldo_shutdown[gi] <= 1'b0;
				end else if (!pwr_reg[`LFIPC_SCP_BIT]) begin
					ldo_shutdown[gi] <= 1'b0;
				end else if (live_q[gi]) begin
					ldo_shutdown[gi] <= 1'b1;
				end else if (flag_clr[gi]) begin
					ldo_shutdown[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	// 32 kHz period as a one-cycle enable
	assign slow_tick = (tick_cnt == 12'(`LFIPC_SLOW_TICK_CYCLES - 32'h1));

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tick_cnt <= 12'h000;
		end else begin
			tick_cnt <= slow_tick ? 12'h000 : tick_cnt + 12'h001;
		end
	end

	// Button debounce in slow periods; a bounce restarts the count
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dbnc_cnt <= 8'h00;
			btn_db   <= 1'b1;
		end else if (btn_s2 == btn_db) begin
			dbnc_cnt <= 8'h00;
		end else if (slow_tick) begin
			if (dbnc_cnt + 8'h01 >= dbnc_ticks(pwr_reg[`LFIPC_DBNC_MSB:`LFIPC_DBNC_LSB])) begin
				btn_db   <= btn_s2;
				dbnc_cnt <= 8'h00;
			end else begin
				dbnc_cnt <= dbnc_cnt + 8'h01;
			end
		end
	end

	assign press_evt = btn_db && !btn_s2 && slow_tick &&
		(dbnc_cnt + 8'h01 >= dbnc_ticks(pwr_reg[`LFIPC_DBNC_MSB:`LFIPC_DBNC_LSB]));

	// Standby request after polarity, then a delay counted in slow ticks, the first period partial
	assign stby_req = stby_s2 ^ pwr_reg[`LFIPC_STBY_INV_BIT];

	always_comb begin
		standby_next = standby_active;
		if (!stby_req) begin
			standby_next = 1'b0;
		end else if (!standby_active &&
			stby_cnt == pwr_reg[`LFIPC_STBY_DLY_MSB:`LFIPC_STBY_DLY_LSB]) begin
			standby_next = 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stby_cnt       <= 2'h0;
			standby_active <= 1'b0;
		end else begin
			standby_active <= standby_next;
			if (!stby_req) begin
				stby_cnt <= 2'h0;
			end else if (!standby_next && slow_tick) begin
				stby_cnt <= stby_cnt + 2'h1;
			end
		end
	end

	// Long press: off after the button is held low, optional restart
	assign restart_ok = pwr_reg[`LFIPC_RESTART_BIT] && cfg_s2;

	always_comb begin
		pstate_next = pstate_reg;
		unique case (pstate_reg)
			PS_ON: begin
				if (pwr_reg[`LFIPC_LP_EN_BIT] && !btn_db) begin
					pstate_next = PS_HOLD;
				end
			end
			PS_HOLD: begin
				if (btn_db || !pwr_reg[`LFIPC_LP_EN_BIT]) begin
					pstate_next = PS_ON;
				end else if (lp_cnt == LONG_PRESS_CYCLES - 32'h1) begin
					pstate_next = PS_OFF;
				end
			end
			PS_OFF: begin
				if (restart_ok) begin
					pstate_next = PS_RESTART;
				end
			end
			PS_RESTART: begin
				// Wait for release so the held button does not power off again
				if (btn_db) begin
					pstate_next = PS_ON;
				end
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pstate_reg    <= PS_ON;
			lp_cnt        <= 32'h0000_0000;
			restart_pulse <= 1'b0;
		end else begin
			pstate_reg    <= pstate_next;
			lp_cnt        <= (pstate_reg == PS_HOLD) ? lp_cnt + 32'h1 : 32'h0000_0000;
			restart_pulse <= (pstate_reg == PS_OFF) && (pstate_next == PS_RESTART);
		end
	end

	assign power_off = (pstate_reg == PS_OFF);

	always_comb begin
		evt_set                     = 4'h0;
		evt_set[`LFIPC_EVT_STBY]    = standby_next && !standby_active;
		evt_set[`LFIPC_EVT_OFF]     = (pstate_next == PS_OFF) && (pstate_reg != PS_OFF);
		evt_set[`LFIPC_EVT_RESTART] = (pstate_reg == PS_OFF) && (pstate_next == PS_RESTART);
		evt_set[`LFIPC_EVT_PRESS]   = press_evt;
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	chk_flag_set: assert property (live_q != 6'h00 |=>
		(flags_reg & $past(live_q)) == $past(live_q))
		else $error("flag not set by current limit");
	chk_flag_clear_only: assert property (
		(~flags_reg & $past(flags_reg) & ~$past(flag_clr)) == 6'h00)
		else $error("flag dropped without a clear write");
	chk_flag_latched: assert property ($fell(live_q[0]) && !flag_clr[0] |=> flags_reg[0])
		else $error("flag lost when condition ended");
	chk_pin_unmasked: assert property (|(flags_reg & ~mask_reg) |=> !interrupt_out_pin_n)
		else $error("unmasked flag not on interrupt pin");
	chk_pin_masked: assert property ((flags_reg & ~mask_reg) == 6'h00 &&
		(evt_reg & evt_en_reg) == 4'h0 |=> interrupt_out_pin_n)
		else $error("masked flag reached interrupt pin");
	chk_charger_out: assert property (wr_b0 && aw_addr_q == `LFIPC_OFF_COIN |=>
		backup_charger_enable == $past(w_data_q[3]) &&
		backup_charger_voltage_sel == $past(w_data_q[2:0]))
		else $error("charger outputs do not follow register");
	chk_short_shutdown: assert property (pwr_reg[`LFIPC_SCP_BIT] && live_q != 6'h00 |=>
		(ldo_shutdown & $past(live_q)) == $past(live_q))
		else $error("LDO not shut down in current limit");
	chk_no_shutdown: assert property (!pwr_reg[`LFIPC_SCP_BIT] |=>
		ldo_shutdown == 6'h00 || $past(wr_b0))
		else $error("shutdown with protection disabled");
	chk_standby_delay: assert property ($rose(standby_active) |->
		$past(stby_cnt) == $past(pwr_reg[`LFIPC_STBY_DLY_MSB:`LFIPC_STBY_DLY_LSB]) &&
		$past(stby_req))
		else $error("standby entered at wrong delay");
	chk_standby_polarity: assert property (standby_active |-> $past(stby_req))
		else $error("standby active without request");
	chk_long_press: assert property ($rose(power_off) |->
		$past(lp_cnt) == LONG_PRESS_CYCLES - 32'h1 && $past(pwr_reg[1]))
		else $error("off mode without full long press");
	chk_auto_restart: assert property (power_off && restart_ok |=>
		restart_pulse && !power_off ##1 !restart_pulse)
		else $error("auto restart missing or not one cycle");
	chk_read_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
		else $error("upper read bits not zero");

	cov_flag_cleared: cover property (flags_reg[3] ##1 !flags_reg[3]);
	cov_standby_enter: cover property ($rose(standby_active));
	cov_power_off: cover property ($rose(power_off));
	cov_restart: cover property (restart_pulse);

endmodule

// ---- dv/lfipc_tb_top.sv ----
// Self-checking bench for the LDO fault flags, charger and power control block.
// Drives the AXI4-Lite slave and every analog-side input itself; 100 MHz clock.
`timescale 1ns/1ps
`include "lfipc_defines.svh"

module lfipc_tb_top
	import lfipc_pkg::*;
;
	localparam int LP    = 200;
	localparam int TICK  = 3125;
	localparam int LIMIT = 95000;

	logic        aclk;
	logic        aresetn;
	logic [7:0]  awaddr;
	logic        awvalid;
	logic        awready;
	logic [31:0] wdata;
	logic [3:0]  wstrb;
	logic        wvalid;
	logic        wready;
	logic [1:0]  bresp;
	logic        bvalid;
	logic        bready;
	logic [7:0]  araddr;
	logic        arvalid;
	logic        arready;
	logic [31:0] rdata;
	logic [1:0]  rresp;
	logic        rvalid;
	logic        rready;
	logic [5:0]  ldo_lim;
	logic        stby_pin;
	logic        btn;
	logic        cfg_sel;
	logic        irq_n;
	logic [5:0]  shut;
	logic        chg_en;
	logic [2:0]  chg_vsel;
	logic        stby_act;
	logic        pwr_off;
	logic        rst_pulse;
	int          n_fail;
	int          num_checks;
	int          cyc;
	logic [7:0]  seed;
	logic [31:0] rd_val;
	logic [1:0]  resp;

	lfipc_top #(.LONG_PRESS_CYCLES(32'(LP))) i_dut (
		.aclk                       (aclk),
		.aresetn                    (aresetn),
		.s_axi_awaddr               (awaddr),
		.s_axi_awvalid              (awvalid),
		.s_axi_awready              (awready),
		.s_axi_wdata                (wdata),
		.s_axi_wstrb                (wstrb),
		.s_axi_wvalid               (wvalid),
		.s_axi_wready               (wready),
		.s_axi_bresp                (bresp),
		.s_axi_bvalid               (bvalid),
		.s_axi_bready               (bready),
		.s_axi_araddr               (araddr),
		.s_axi_arvalid              (arvalid),
		.s_axi_arready              (arready),
		.s_axi_rdata                (rdata),
		.s_axi_rresp                (rresp),
		.s_axi_rvalid               (rvalid),
		.s_axi_rready               (rready),
		.ldo_current_limit          (ldo_lim),
		.standby_pin                (stby_pin),
		.power_button_input         (btn),
		.power_config_select        (cfg_sel),
		.interrupt_out_pin_n        (irq_n),
		.ldo_shutdown               (shut),
		.backup_charger_enable      (chg_en),
		.backup_charger_voltage_sel (chg_vsel),
		.standby_active             (stby_act),
		.power_off                  (pwr_off),
		.restart_pulse              (rst_pulse)
	);

	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end

	task automatic finish_test();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// Hang guard sized from the longest waits below
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			n_fail++;
			finish_test();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		num_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction

	function automatic logic irq_n_exp(input logic [5:0] f, input logic [5:0] m);
		return ~|(f & ~m);
	endfunction

	task automatic tick(input int n);
		repeat (n) @(posedge aclk);
	endtask

	// Sampled right after an edge, so values are those the edge saw
	task automatic wait_hi(ref logic s, input int lim, output int n);
		n = 0;
		while (s !== 1'b1 && n < lim) begin
			@(posedge aclk);
			n++;
		end
	endtask

	// Ready and response readiness stay high; bready and rready are never lowered
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw_ok;
		logic w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wstrb <= 4'hF;
		wvalid <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge aclk);
			if (awvalid && awready) begin
				aw_ok = 1'b1;
				awvalid <= 1'b0;
			end
			if (wvalid && wready) begin
				w_ok = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (!bvalid);
		r = bresp;
	endtask

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge aclk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge aclk); while (!rvalid);
		d = rdata;
		r = rresp;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] r;
		axi_wr(a, d, r);
		check({30'h0, r}, {30'h0, `LFIPC_RESP_OKAY}, "write response");
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string what);
		logic [31:0] d;
		logic [1:0]  r;
		axi_rd(a, d, r);
		check({30'h0, r}, {30'h0, `LFIPC_RESP_OKAY}, what);
		check(d, e, what);
	endtask

	task automatic do_reset();
		aresetn <= 1'b0;
		tick(16);
		aresetn <= 1'b1;
	endtask

	initial begin
		logic [5:0] pat;
		logic [5:0] clr;
		logic [5:0] msk;
		int         n;
		n_fail = 0;
		num_checks = 0;
		cyc = 0;
		seed = 8'h63;
		{aresetn, awaddr, awvalid, wdata, wstrb, wvalid, araddr, arvalid} = '0;
		{bready, rready, btn} = 3'h7;
		{ldo_lim, stby_pin, cfg_sel} = '0;
		do_reset();
		check({31'h0, irq_n}, 32'h1, "pin after reset");
		rd_chk(`LFIPC_OFF_FLAGS, 32'h0, "flags reset");
		rd_chk(`LFIPC_OFF_MASK, 32'h3F, "mask reset");
		rd_chk(`LFIPC_OFF_LIVE, 32'h0, "live reset");
		rd_chk(`LFIPC_OFF_COIN, 32'h0, "charger reset");
		rd_chk(`LFIPC_OFF_PWR, 32'h10, "power ctrl reset");
		axi_rd(8'h24, rd_val, resp);
		check({30'h0, resp}, {30'h0, `LFIPC_RESP_SLVERR}, "unmapped read");
		axi_wr(8'h20, 32'h0, resp);
		check({30'h0, resp}, {30'h0, `LFIPC_RESP_SLVERR}, "unmapped write");
		for (int k = 0; k < 8; k++) begin
			seed = lfsr(seed);
			pat = (k == 0) ? 6'h3F : seed[5:0];
			clr = seed[7:2];
			msk = (k == 0) ? 6'h37 : {seed[0], seed[7:3]};
			ldo_lim <= pat;
			tick(5);
			rd_chk(`LFIPC_OFF_LIVE, {26'h0, pat}, "live follows limit");
			ldo_lim <= 6'h00;
			tick(5);
			rd_chk(`LFIPC_OFF_LIVE, 32'h0, "live back to normal");
			rd_chk(`LFIPC_OFF_FLAGS, {26'h0, pat}, "flags latched");
			check({26'h0, shut}, 32'h0, "no shutdown, protect off");
			wr(`LFIPC_OFF_FLAGS, 32'h0);
			rd_chk(`LFIPC_OFF_FLAGS, {26'h0, pat}, "zero write keeps flags");
			wr(`LFIPC_OFF_MASK, {24'hA5A5A5, 2'h3, msk});
			rd_chk(`LFIPC_OFF_MASK, {26'h0, msk}, "mask readback");
			tick(2);
			check({31'h0, irq_n}, {31'h0, irq_n_exp(pat, msk)}, "pin vs mask");
			wr(`LFIPC_OFF_FLAGS, {26'h0, clr});
			rd_chk(`LFIPC_OFF_FLAGS, {26'h0, pat & ~clr}, "one clears flag");
			tick(2);
			check({31'h0, irq_n}, {31'h0, irq_n_exp(pat & ~clr, msk)}, "pin after clear");
			wr(`LFIPC_OFF_FLAGS, 32'h3F);
			wr(`LFIPC_OFF_MASK, 32'h0);
			tick(2);
			check({31'h0, irq_n}, 32'h1, "pin idle unmasked");
		end
		for (int v = 0; v < 16; v++) begin
			wr(`LFIPC_OFF_COIN, 32'(v));
			rd_chk(`LFIPC_OFF_COIN, 32'(v), "charger readback");
			check({28'h0, chg_en, chg_vsel}, 32'(v), "charger outputs");
		end
		wr(`LFIPC_OFF_MASK, 32'h3F);
		wr(`LFIPC_OFF_PWR, 32'h80);
		seed = lfsr(seed);
		pat = seed[5:0] | 6'h01;
		ldo_lim <= pat;
		tick(6);
		check({26'h0, shut}, {26'h0, pat}, "limited LDO shut down");
		ldo_lim <= 6'h00;
		tick(5);
		wr(`LFIPC_OFF_FLAGS, 32'h01);
		check({26'h0, shut}, {26'h0, pat & 6'h3E}, "shutdown after flag clear");
		wr(`LFIPC_OFF_PWR, 32'h00);
		tick(2);
		check({26'h0, shut}, 32'h0, "protect off releases");
		wr(`LFIPC_OFF_FLAGS, 32'h3F);
		// Button press event, debounce 1 period, long-press off disabled
		wr(`LFIPC_OFF_EVT_EN, 32'h8);
		btn <= 1'b0;
		tick(3 * TICK);
		btn <= 1'b1;
		check({31'h0, pwr_off}, 32'h0, "no off when disabled");
		check({31'h0, irq_n}, 32'h0, "pin on enabled event");
		rd_chk(`LFIPC_OFF_EVT_STAT, 32'h8, "press event");
		wr(`LFIPC_OFF_EVT_EN, 32'h0);
		tick(2);
		check({31'h0, irq_n}, 32'h1, "event masked");
		wr(`LFIPC_OFF_EVT_CLR, 32'h8);
		rd_chk(`LFIPC_OFF_EVT_STAT, 32'h0, "event cleared");
		rd_chk(`LFIPC_OFF_EVT_CLR, 32'h0, "clear reads zero");
		tick(2 * TICK);
		wr(`LFIPC_OFF_PWR, 32'h04);
		btn <= 1'b0;
		tick(2 * TICK);
		btn <= 1'b1;
		tick(TICK);
		rd_chk(`LFIPC_OFF_EVT_STAT, 32'h0, "short press filtered");
		for (int d = 0; d < 4; d++) begin
			wr(`LFIPC_OFF_PWR, {26'h0, d[1:0], 4'h0});
			stby_pin <= 1'b1;
			wait_hi(stby_act, 4 * TICK + 20, n);
			check({31'h0, n <= d * TICK + 6 && n + TICK >= d * TICK}, 32'h1, "standby delay");
			stby_pin <= 1'b0;
			tick(4);
			check({31'h0, stby_act}, 32'h0, "standby left");
		end
		wr(`LFIPC_OFF_PWR, 32'h40);
		tick(6);
		check({31'h0, stby_act}, 32'h1, "inverted pin low requests");
		stby_pin <= 1'b1;
		tick(4);
		check({31'h0, stby_act}, 32'h0, "inverted pin high idle");
		stby_pin <= 1'b0;
		// Long press without restart permission: off holds
		wr(`LFIPC_OFF_PWR, 32'h03);
		btn <= 1'b0;
		wait_hi(pwr_off, 3 * TICK + LP + 20, n);
		check({31'h0, pwr_off}, 32'h1, "long press off");
		btn <= 1'b1;
		n = 0;
		repeat (500) begin
			tick(1);
			n += (rst_pulse !== 1'b0 || pwr_off !== 1'b1) ? 1 : 0;
		end
		check(32'(n), 32'h0, "off holds, config low");
		do_reset();
		tick(1);
		check({31'h0, pwr_off}, 32'h0, "reset leaves off");
		rd_chk(`LFIPC_OFF_PWR, 32'h10, "power ctrl after reset");
		cfg_sel <= 1'b1;
		wr(`LFIPC_OFF_PWR, 32'h03);
		btn <= 1'b0;
		wait_hi(rst_pulse, 3 * TICK + LP + 40, n);
		check({31'h0, rst_pulse}, 32'h1, "auto restart pulse");
		btn <= 1'b1;
		tick(4);
		check({31'h0, pwr_off}, 32'h0, "on after restart");
		finish_test();
	end
endmodule
